// ### rsync_pkg.sv
package rsync_pkg;
	// register byte offsets
	localparam logic [11:0] OFF_BANK00 = 12'h000;
	localparam logic [11:0] OFF_BANK10 = 12'h004;
	localparam logic [11:0] OFF_STATUS = 12'h008;
	localparam logic [11:0] OFF_FIFO = 12'h00c;
	// bank (0,0) field
	localparam int BIT_SERVO_EN = 12;
	// bank (1,0) fields
	localparam int BIT_SYNC_PD = 2;
	localparam int BIT_CP_RATIO = 12;
	// power-up values
	localparam logic [31:0] RST_BANK00 = 32'h0000_0000;
	localparam logic [31:0] RST_BANK10 = 32'h0000_0000;
	// charge pump current gains per {ratio bit, gain pin}
	localparam logic [3:0] GAIN_00 = 4'h8;
	localparam logic [3:0] GAIN_01 = 4'h4;
	localparam logic [3:0] GAIN_10 = 4'h8;
	localparam logic [3:0] GAIN_11 = 4'h2;
	localparam logic [3:0] GAIN_UNLOCKED = 4'h1;
	// sync field divider moduli
	localparam logic [1:0] DIV_2T = 2'h2;
	localparam logic [1:0] DIV_3T = 2'h3;
	// lock detect: consecutive aligned data bits
	localparam logic [7:0] LOCK_COUNT = 8'h10;
	// fifo shape
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 8;
	// clock-mux dead time in system cycles
	localparam logic [1:0] MUX_GAP = 2'h2;
	typedef enum logic [5:0]
	{
		ST_IDLE = 6'b000001,
		ST_FREEZE = 6'b000010,
		ST_SW_IN = 6'b000100,
		ST_READ = 6'b001000,
		ST_SW_OUT = 6'b010000,
		ST_RELOCK = 6'b100000
	} seq_state_t;
endpackage

// ### rsync_sync3.sv
`timescale 1ns/1ps
// three-stage input synchroniser with agreement filter
module rsync_sync3
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// async in, filtered out
	input wire logic d,
	output logic q
);
	logic s1_r; // metastable stage, read only by s2_r
	logic s2_r;
	logic s3_r;
	// shift chain
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end
		else
		begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	// change counts once stages two and three agree
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			q <= 1'b0;
		else if (s2_r == s3_r)
			q <= s3_r;
	end
endmodule

// ### rsync_fifo.sv
`timescale 1ns/1ps
// small synchronous fifo, valid/ready both sides
module rsync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r; // fill level, one wider for full
	logic push;
	logic pop;
	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem[rp_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// storage write, no reset needed on data
	always_ff @(posedge hclk)
	begin
		if (push)
			mem[wp_r] <= in_data;
	end
	// pointers and level
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule

// ### read_sync_clock_sequencer.sv
// Contract
// [RL1] idle: loop tracks synthesizer reference
// [RL2] read gate starts zero phase start
// [RL3] clock mux switches after restart, glitch-free
// [RL4] freq lock low inserts 2T/3T divider
// [RL5] freq lock high drops divider, gate on
// [RL6] no freq lock: gate on after restart
// [RL7] exit: mux back first, then restart
// [RL8] power-down bit idles sync, biases pump
// [RL9] power-on: non-read mode, bias off
// [RL10] hold in read disables charge pump
// [RL11] controller asserts hold over bursts/defects
// [RL12] lock detect switches pump gain by factor
// [RL13] unselected agc input held
// [RL14] window from recovered clock, always on
// [RL15] servo select pin chooses agc input
// [RL16] servo enable lets pin swap peaking
// [RL17] gains 8,4,8,2 for ratio/pin states
// [RL18] hold ignored outside read mode
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module read_sync_clock_sequencer
(
	// system clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// asynchronous pins from the controller
	input wire logic read_gate_pin,
	input wire logic freq_lock_control,
	input wire logic freq_lock_used,
	input wire logic sync_field_3t,
	input wire logic hold_coast,
	input wire logic cp_gain_select_pin,
	input wire logic servo_field_select,
	// clocks and data, sampled as pins
	input wire logic synth_clk,
	input wire logic vco_clk,
	input wire logic read_data,
	// outputs
	output logic sync_clk_out,
	output logic sync_data_out,
	output logic charge_pump_en,
	output logic charge_pump_idle_bias,
	output logic [3:0] cp_current_gain,
	output logic agc_in_data_sel,
	output logic agc_in_servo_sel,
	output logic servo_peak_sel,
	output logic pulse_gate_en,
	output logic fb_div_en,
	output logic [1:0] fb_div_mod,
	output logic vco_frozen
);
	// synchronised pin levels
	logic gate_s, lkc_s, flu_s, t3_s, hold_s, gpin_s, sfs_s, syn_s, vco_s, rd_s;
	rsync_sync3 u_s0 (.hclk(hclk), .hresetn(hresetn), .d(read_gate_pin), .q(gate_s));
	rsync_sync3 u_s1 (.hclk(hclk), .hresetn(hresetn), .d(freq_lock_control), .q(lkc_s));
	rsync_sync3 u_s2 (.hclk(hclk), .hresetn(hresetn), .d(freq_lock_used), .q(flu_s));
	rsync_sync3 u_s3 (.hclk(hclk), .hresetn(hresetn), .d(sync_field_3t), .q(t3_s));
	rsync_sync3 u_s4 (.hclk(hclk), .hresetn(hresetn), .d(hold_coast), .q(hold_s));
	rsync_sync3 u_s5 (.hclk(hclk), .hresetn(hresetn), .d(cp_gain_select_pin), .q(gpin_s));
	rsync_sync3 u_s6 (.hclk(hclk), .hresetn(hresetn), .d(servo_field_select), .q(sfs_s));
	rsync_sync3 u_s7 (.hclk(hclk), .hresetn(hresetn), .d(synth_clk), .q(syn_s));
	rsync_sync3 u_s8 (.hclk(hclk), .hresetn(hresetn), .d(vco_clk), .q(vco_s));
	rsync_sync3 u_s9 (.hclk(hclk), .hresetn(hresetn), .d(read_data), .q(rd_s));

	// register state
	logic [31:0] bank00_r;
	logic [31:0] bank10_r;
	logic sync_pd;
	assign sync_pd = bank10_r[rsync_pkg::BIT_SYNC_PD];

	// edge history
	logic vco_d_r, rd_d_r;
	logic vco_rise, rd_rise;
	assign vco_rise = vco_s && !vco_d_r;
	assign rd_rise = rd_s && !rd_d_r;
	// edge detect registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			vco_d_r <= 1'b0;
			rd_d_r <= 1'b0;
		end
		else
		begin
			vco_d_r <= vco_s;
			rd_d_r <= rd_s;
		end
	end

	// sequencer
	rsync_pkg::seq_state_t st_r;
	logic [1:0] gap_r; // mux dead time
	logic restart_r; // pulse when vco restarted
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_r <= rsync_pkg::ST_IDLE;
			gap_r <= '0;
			restart_r <= 1'b0;
		end
		else if (sync_pd)
		begin
			// power-down forces non-read mode [RL9]
			st_r <= rsync_pkg::ST_IDLE;
			gap_r <= '0;
			restart_r <= 1'b0;
		end
		else
		begin
			restart_r <= 1'b0;
			case (st_r)
				rsync_pkg::ST_IDLE:
					if (gate_s)
						st_r <= rsync_pkg::ST_FREEZE; // [RL2]
				rsync_pkg::ST_FREEZE:
					// restart on first data bit [RL2]
					if (!gate_s)
						st_r <= rsync_pkg::ST_IDLE;
					else if (rd_rise)
					begin
						st_r <= rsync_pkg::ST_SW_IN;
						gap_r <= rsync_pkg::MUX_GAP;
						restart_r <= 1'b1;
					end
				rsync_pkg::ST_SW_IN:
					// hold mux low for dead time before switching [RL3]
					if (gap_r != '0)
						gap_r <= gap_r - 1'b1;
					else
						st_r <= rsync_pkg::ST_READ;
				rsync_pkg::ST_READ:
					if (!gate_s)
					begin
						st_r <= rsync_pkg::ST_SW_OUT; // [RL7]
						gap_r <= rsync_pkg::MUX_GAP;
					end
				rsync_pkg::ST_SW_OUT:
					// restart held off while mux returns [RL7]
					if (gap_r != '0)
						gap_r <= gap_r - 1'b1;
					else
						st_r <= rsync_pkg::ST_RELOCK;
				rsync_pkg::ST_RELOCK:
					// relock alignment is loose, one vco edge enough
					if (vco_rise)
						st_r <= rsync_pkg::ST_IDLE;
				default:
					st_r <= rsync_pkg::ST_IDLE;
			endcase
		end
	end

	logic in_read;
	assign in_read = (st_r == rsync_pkg::ST_READ);

	// sync clock mux: low during gaps so no runt pulses [RL3] [RL7]
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sync_clk_out <= 1'b0;
		else if (in_read)
			sync_clk_out <= vco_s;
		else if (st_r == rsync_pkg::ST_SW_IN || st_r == rsync_pkg::ST_SW_OUT)
			sync_clk_out <= 1'b0;
		else
			sync_clk_out <= syn_s; // [RL1]
	end

	// vco freeze during entry and exit restart
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			vco_frozen <= 1'b0;
		else
			vco_frozen <= (st_r == rsync_pkg::ST_FREEZE) || (st_r == rsync_pkg::ST_RELOCK); // [RL2]
	end

	// frequency lock divider and pulse gate
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fb_div_en <= 1'b0;
			fb_div_mod <= rsync_pkg::DIV_2T;
			pulse_gate_en <= 1'b0;
		end
		else if (!in_read)
		begin
			fb_div_en <= 1'b0;
			pulse_gate_en <= 1'b0;
		end
		else if (flu_s && !lkc_s)
		begin
			fb_div_en <= 1'b1; // [RL4]
			fb_div_mod <= t3_s ? rsync_pkg::DIV_3T : rsync_pkg::DIV_2T; // [RL4]
			pulse_gate_en <= 1'b0;
		end
		else
		begin
			// divider drops out on a vco edge when freq lock is used, at once when it is not [RL5] [RL6]
			if (!flu_s || vco_rise)
			begin
				fb_div_en <= 1'b0;
				pulse_gate_en <= 1'b1;
			end
		end
	end

	// lock detect: run of data bits while the pulse gate is on
	logic [7:0] lock_cnt_r;
	logic locked;
	assign locked = (lock_cnt_r == rsync_pkg::LOCK_COUNT);
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			lock_cnt_r <= '0;
		else if (!pulse_gate_en)
			lock_cnt_r <= '0;
		else if (rd_rise && !locked)
			lock_cnt_r <= lock_cnt_r + 1'b1;
	end

	// gain table lookup
	function automatic logic [3:0] gain_of(input logic ratio, input logic pin);
		case ({ratio, pin})
			2'b00: gain_of = rsync_pkg::GAIN_00;
			2'b01: gain_of = rsync_pkg::GAIN_01;
			2'b10: gain_of = rsync_pkg::GAIN_10;
			default: gain_of = rsync_pkg::GAIN_11;
		endcase
	endfunction

	// charge pump control
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			charge_pump_en <= 1'b1;
			charge_pump_idle_bias <= 1'b0;
			cp_current_gain <= rsync_pkg::GAIN_UNLOCKED;
		end
		else
		begin
			charge_pump_idle_bias <= sync_pd; // [RL8] [RL9]
			// hold only gates the pump in read mode [RL10] [RL18]
			charge_pump_en <= !sync_pd && !(in_read && hold_s); // [RL10]
			cp_current_gain <= locked ? gain_of(bank10_r[rsync_pkg::BIT_CP_RATIO], gpin_s)
				: rsync_pkg::GAIN_UNLOCKED; // [RL12] [RL17]
		end
	end

	// agc and peaking selection
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			agc_in_data_sel <= 1'b1;
			agc_in_servo_sel <= 1'b0;
			servo_peak_sel <= 1'b0;
		end
		else
		begin
			agc_in_data_sel <= !sfs_s; // [RL13] [RL15]
			agc_in_servo_sel <= sfs_s; // [RL13] [RL15]
			servo_peak_sel <= sfs_s && bank00_r[rsync_pkg::BIT_SERVO_EN]; // [RL16]
		end
	end

	// bit latch: data sampled on every vco edge, gate-independent [RL14]
	logic fifo_in_ready, fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic [7:0] shift_r;
	logic [2:0] nbit_r;
	logic bit_seen_r;
	logic push_r;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bit_seen_r <= 1'b0;
			sync_data_out <= 1'b0;
			shift_r <= '0;
			nbit_r <= '0;
			push_r <= 1'b0;
		end
		else
		begin
			if (push_r && fifo_in_ready)
				push_r <= 1'b0;
			if (rd_rise)
				bit_seen_r <= 1'b1;
			if (vco_rise)
			begin
				sync_data_out <= bit_seen_r || rd_rise; // [RL14]
				bit_seen_r <= 1'b0;
				// bytes collect in read mode; while fifo full the held byte waits and new bits are dropped
				if (in_read && !push_r)
				begin
					shift_r <= {shift_r[6:0], bit_seen_r || rd_rise};
					nbit_r <= nbit_r + 1'b1;
					push_r <= (nbit_r == 3'h7);
				end
			end
		end
	end

	logic rd_fifo;
	rsync_fifo #(.WIDTH(rsync_pkg::FIFO_W), .DEPTH(rsync_pkg::FIFO_D)) u_fifo
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.in_valid(push_r),
		.in_ready(fifo_in_ready),
		.in_data(shift_r),
		.out_valid(fifo_out_valid),
		.out_ready(rd_fifo),
		.out_data(fifo_out_data)
	);

	// ahb address phase capture
	logic ap_valid_r, ap_write_r;
	logic [11:0] ap_addr_r;
	logic take;
	assign take = hsel && hready && htrans[1];
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap_valid_r <= 1'b0;
			ap_write_r <= 1'b0;
			ap_addr_r <= '0;
		end
		else if (hready)
		begin
			ap_valid_r <= take;
			ap_write_r <= hwrite;
			ap_addr_r <= haddr;
		end
	end
	assign rd_fifo = take && !hwrite && (haddr == rsync_pkg::OFF_FIFO);

	// register writes in data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bank00_r <= rsync_pkg::RST_BANK00;
			bank10_r <= rsync_pkg::RST_BANK10;
		end
		else if (ap_valid_r && ap_write_r)
		begin
			if (ap_addr_r == rsync_pkg::OFF_BANK00)
				bank00_r <= hwdata;
			if (ap_addr_r == rsync_pkg::OFF_BANK10)
				bank10_r <= hwdata; // [RL8]
		end
	end

	// read data registered at address phase, zero-wait
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= '0;
		else if (take && !hwrite)
			case (haddr)
				rsync_pkg::OFF_BANK00: hrdata <= bank00_r;
				rsync_pkg::OFF_BANK10: hrdata <= bank10_r;
				rsync_pkg::OFF_STATUS: hrdata <= {20'h0_0000, cp_current_gain, 2'h0, st_r};
				// empty buffer reads a zero byte, not stale storage
				rsync_pkg::OFF_FIFO: hrdata <= {23'h00_0000, fifo_out_valid, fifo_out_valid ? fifo_out_data : 8'h00};
				default: hrdata <= 32'h0000_0000;
			endcase
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// read gate seen high enters the freeze state next cycle
	property p_freeze_start; // [RL2]
		@(posedge hclk) disable iff (!hresetn)
		(st_r == rsync_pkg::ST_IDLE && gate_s && !sync_pd) |=> (st_r == rsync_pkg::ST_FREEZE);
	endproperty
	a_freeze_start: assert property (p_freeze_start) else $error("freeze not started"); // [RL2]
	// three switch cycles, mux low in the last two, then read mode with mux still low
	sequence s_sw_in;
		(st_r == rsync_pkg::ST_SW_IN) ##1 (st_r == rsync_pkg::ST_SW_IN && !sync_clk_out) [*2]
			##1 (st_r == rsync_pkg::ST_READ && !sync_clk_out);
	endsequence
	property p_mux_after_restart; // [RL3]
		@(posedge hclk) disable iff (!hresetn || sync_pd)
		restart_r |-> s_sw_in;
	endproperty
	a_mux_after_restart: assert property (p_mux_after_restart) else $error("mux switched early"); // [RL3]
	property p_div; // [RL4]
		@(posedge hclk) disable iff (!hresetn)
		(in_read && flu_s && !lkc_s) |=> fb_div_en && !pulse_gate_en;
	endproperty
	a_div: assert property (p_div) else $error("divider missing"); // [RL4]
	property p_nofl; // [RL6]
		@(posedge hclk) disable iff (!hresetn)
		(in_read && !flu_s) |=> pulse_gate_en || !in_read;
	endproperty
	a_nofl: assert property (p_nofl) else $error("pulse gate not on"); // [RL6]
	property p_exit; // [RL7]
		@(posedge hclk) disable iff (!hresetn)
		(in_read && !gate_s && !sync_pd) |=> (st_r == rsync_pkg::ST_SW_OUT) ##1 !vco_frozen [*2];
	endproperty
	a_exit: assert property (p_exit) else $error("restart not held off"); // [RL7]
	property p_pd; // [RL8]
		@(posedge hclk) disable iff (!hresetn)
		sync_pd |=> charge_pump_idle_bias && !charge_pump_en;
	endproperty
	a_pd: assert property (p_pd) else $error("power-down not applied"); // [RL8]
	property p_hold; // [RL10]
		@(posedge hclk) disable iff (!hresetn)
		(in_read && hold_s) |=> !charge_pump_en;
	endproperty
	a_hold: assert property (p_hold) else $error("pump active in hold"); // [RL10]
	property p_hold_idle; // [RL18]
		@(posedge hclk) disable iff (!hresetn)
		(!in_read && !sync_pd) |=> charge_pump_en;
	endproperty
	a_hold_idle: assert property (p_hold_idle) else $error("pump off outside read"); // [RL18]
	property p_agc; // [RL13]
		@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> (agc_in_data_sel != agc_in_servo_sel) && (agc_in_servo_sel == $past(sfs_s));
	endproperty
	a_agc: assert property (p_agc) else $error("agc select wrong"); // [RL13]
endmodule

// ### rsync_partner.sv
`timescale 1ns/1ps
// far side: controller plus synthesizer and recovered clock sources
module rsync_partner
(
	// control from the bench
	input wire logic run,
	input wire logic hold_req,
	// pins toward the block
	output logic synth_clk,
	output logic vco_clk,
	output logic read_data,
	output logic hold_coast
);
	// synthesizer runs free, phase offset from hclk on purpose
	initial
	begin
		synth_clk = 1'h0;
		#7;
		forever #32 synth_clk = ~synth_clk;
	end
	// recovered clock stands low outside a read frame
	initial
	begin
		vco_clk = 1'h0;
		forever
		begin
			#32;
			vco_clk = run ? ~vco_clk : 1'h0;
		end
	end
	// one data bit per recovered period; all-ones keeps bytes alignment-free
	assign read_data = vco_clk;
	// hold raised for the whole burst or defect
	assign hold_coast = hold_req;
endmodule

// ### read_sync_clock_sequencer_test.sv
`timescale 1ns/1ps
module read_sync_clock_sequencer_test;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, run, hold_req;
	logic [11:0] haddr;
	logic [1:0] htrans, fb_div_mod;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic read_gate_pin, freq_lock_control, freq_lock_used, sync_field_3t, cp_gain_select_pin, servo_field_select;
	logic synth_clk, vco_clk, read_data, hold_coast, sync_clk_out, sync_data_out, vco_frozen;
	logic charge_pump_en, charge_pump_idle_bias, agc_in_data_sel, agc_in_servo_sel, servo_peak_sel;
	logic pulse_gate_en, fb_div_en;
	logic [3:0] cp_current_gain;
	logic [3:0] gains [4] = '{4'h8, 4'h4, 4'h8, 4'h2};
	int n_errors, checked, cycles, n, m, g, i;
	// system clock, 5 ns
	initial
	begin
		hclk = 1'h0;
		forever #2.5 hclk = ~hclk;
	end
	read_sync_clock_sequencer read_sync_clock_sequencer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .read_gate_pin(read_gate_pin),
		.freq_lock_control(freq_lock_control), .freq_lock_used(freq_lock_used), .sync_field_3t(sync_field_3t),
		.hold_coast(hold_coast), .cp_gain_select_pin(cp_gain_select_pin), .servo_field_select(servo_field_select),
		.synth_clk(synth_clk), .vco_clk(vco_clk), .read_data(read_data), .sync_clk_out(sync_clk_out),
		.sync_data_out(sync_data_out), .charge_pump_en(charge_pump_en), .charge_pump_idle_bias(charge_pump_idle_bias),
		.cp_current_gain(cp_current_gain), .agc_in_data_sel(agc_in_data_sel), .agc_in_servo_sel(agc_in_servo_sel),
		.servo_peak_sel(servo_peak_sel), .pulse_gate_en(pulse_gate_en), .fb_div_en(fb_div_en),
		.fb_div_mod(fb_div_mod), .vco_frozen(vco_frozen));
	rsync_partner rsync_partner_i (.run(run), .hold_req(hold_req), .synth_clk(synth_clk), .vco_clk(vco_clk),
		.read_data(read_data), .hold_coast(hold_coast));
	// compare and count
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// single verdict point
	task final_report;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ahb-lite single word read; data taken at the data-phase edge
	task bus_rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= 1'h0;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		d = hrdata;
	endtask
	// ahb-lite single word write
	task bus_wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= 1'h1;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
	endtask
	// pins pass a three-flop synchroniser
	task settle;
		repeat (8) @(posedge hclk);
	endtask
	// poll the sequencer state, bounded
	task st(input logic [5:0] s, input string nm);
		for (i = 0; i < 300; i++)
		begin
			bus_rd(rsync_pkg::OFF_STATUS, rd);
			if (rd[5:0] === s)
				break;
		end
		check(nm, {26'h0, rd[5:0]}, {26'h0, s});
	endtask
	// high cycles of sync clock (0) or sync data (1) over 200 cycles
	task count_high(input logic sel, output int cnt);
		cnt = 0;
		repeat (200)
		begin
			@(posedge hclk);
			cnt += ((sel ? sync_data_out : sync_clk_out) === 1'h1);
		end
	endtask
	// hang guard, well above the expected run length
	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			n_errors++;
			final_report;
		end
	end
	initial
	begin
		{hresetn, hsel, hwrite, run, hold_req, haddr, htrans, hwdata} = '0;
		hsize = 3'h2;
		{read_gate_pin, freq_lock_control, freq_lock_used, sync_field_3t} = 4'h0;
		{cp_gain_select_pin, servo_field_select} = 2'h0;
		repeat (16) @(posedge hclk);
		// power-up state while still in reset
		check("pump enable", charge_pump_en, 1);
		check("idle bias", charge_pump_idle_bias, 0);
		check("gain", cp_current_gain, 1);
		hresetn <= 1'h1;
		bus_rd(rsync_pkg::OFF_BANK10, rd);
		check("bank10", rd, rsync_pkg::RST_BANK10);
		check("bus response", {hreadyout, hresp}, 2'h2);
		bus_rd(12'h010, rd);
		check("unmapped", rd, 32'h0000_0000);
		st(rsync_pkg::ST_IDLE, "idle");
		count_high(0, n);
		check("synth on sync clock", n > 60 && n < 140, 1);
		hold_req <= 1'h1;
		settle;
		check("pump outside read", charge_pump_en, 1);
		hold_req <= 1'h0;
		$display("test reset and idle done");
		// agc input and peaking selection
		servo_field_select <= 1'h1;
		settle;
		check("agc servo", {agc_in_servo_sel, agc_in_data_sel}, 2'h2);
		check("peak no enable", servo_peak_sel, 0);
		bus_wr(rsync_pkg::OFF_BANK00, 32'h0000_1000);
		settle;
		check("peak enabled", servo_peak_sel, 1);
		servo_field_select <= 1'h0;
		settle;
		check("agc data", {agc_in_servo_sel, agc_in_data_sel}, 2'h1);
		check("peak data", servo_peak_sel, 0);
		bus_wr(rsync_pkg::OFF_BANK00, 32'h0000_0000);
		$display("test agc done");
		// reads: 3T freq lock, 2T freq lock, no freq lock
		for (m = 0; m < 3; m++)
		begin
			freq_lock_used <= (m < 2);
			sync_field_3t <= (m == 0);
			freq_lock_control <= 1'h0;
			read_gate_pin <= 1'h1;
			settle;
			check("frozen", vco_frozen, 1);
			st(rsync_pkg::ST_FREEZE, "freeze");
			run <= 1'h1;
			st(rsync_pkg::ST_READ, "read");
			check("restarted", vco_frozen, 0);
			check("divider", fb_div_en, m < 2);
			check("pulse gate", pulse_gate_en, m == 2);
			if (m < 2)
				check("modulus", fb_div_mod, m == 0 ? 2'h3 : 2'h2);
			count_high(0, n);
			check("vco on sync clock", n > 60 && n < 140, 1);
			if (m == 0)
			begin
				count_high(1, n);
				check("window before gate", n > 0, 1);
				check("gain unlocked", cp_current_gain, 1);
				freq_lock_control <= 1'h1;
				repeat (30) @(posedge hclk);
				check("divider dropped", fb_div_en, 0);
				check("gate on", pulse_gate_en, 1);
				repeat (400) @(posedge hclk);
				for (g = 0; g < 4; g++)
				begin
					bus_wr(rsync_pkg::OFF_BANK10, {19'h0, g[1], 12'h0});
					cp_gain_select_pin <= g[0];
					settle;
					check("locked gain", cp_current_gain, gains[g]);
				end
				hold_req <= 1'h1;
				settle;
				check("pump held", charge_pump_en, 0);
				hold_req <= 1'h0;
				settle;
				check("pump resumed", charge_pump_en, 1);
				repeat (600) @(posedge hclk);
			end
			read_gate_pin <= 1'h0;
			for (i = 0; i < 100; i++)
			begin
				bus_rd(rsync_pkg::OFF_STATUS, rd);
				if (rd[5:0] !== rsync_pkg::ST_READ)
					break;
			end
			check("mux back first", rd[5:0], rsync_pkg::ST_SW_OUT);
			st(rsync_pkg::ST_IDLE, "relocked");
			run <= 1'h0;
			$display("test read mode %0d done", m);
		end
		// drain: eight stored bytes plus the one held at the full input, then empty
		for (g = 0; g < 10; g++)
		begin
			bus_rd(rsync_pkg::OFF_FIFO, rd);
			check("fifo pop", rd, g < 9 ? 32'h0000_01ff : 32'h0000_0000);
		end
		$display("test fifo done");
		// selective power-down and power-on
		bus_wr(rsync_pkg::OFF_BANK10, 32'h0000_0004);
		read_gate_pin <= 1'h1;
		settle;
		check("bias on", charge_pump_idle_bias, 1);
		bus_rd(rsync_pkg::OFF_STATUS, rd);
		check("no read when down", rd[5:0], rsync_pkg::ST_IDLE);
		read_gate_pin <= 1'h0;
		bus_wr(rsync_pkg::OFF_BANK10, 32'h0000_0000);
		settle;
		check("bias off", charge_pump_idle_bias, 0);
		st(rsync_pkg::ST_IDLE, "non-read after power-on");
		$display("test power-down done");
		final_report;
	end
endmodule
